// file: rtl/sbc_device.sv
/*
  Special bus cycle sequencer: interrupt acknowledge pairs, halt and
  shutdown cycles, refresh cycles and 8-bit sizing of reads and writes.
  Assumes the system logic on the same clock answers over sbc_bus_if.
*/
`timescale 1ns/1ps
module sbc_device (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Local bus
  sbc_bus_if.dev bus,
  // Access requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_high_n,
  input wire logic req_low_n,
  input wire logic [sbc_pkg::ADDR_W:1] req_addr,
  input wire logic [sbc_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [sbc_pkg::DATA_W-1:0] resp_rdata,
  // Interrupts
  input wire logic maskable_irq_in,
  input wire logic irq_enable,
  input wire logic nmi_in,
  input wire logic cascade_enable,
  input wire logic [2:0] cascade_sel,
  input wire logic vector_external,
  input wire logic [sbc_pkg::VEC_W-1:0] internal_vector,
  output logic vector_valid,
  output logic [sbc_pkg::VEC_W-1:0] irq_vector,
  // Halt, refresh and coprocessor
  input wire logic halt_req,
  input wire logic shutdown_req,
  output logic halted,
  input wire logic refresh_req,
  input wire logic [sbc_pkg::ADDR_W:1] refresh_addr,
  output logic refresh_done,
  input wire logic coproc_request,
  output logic coproc_grant
);
  sbc_pkg::sbc_state_t state, next_state;
  sbc_pkg::sbc_cycle_t cycle, next_cycle;
  logic [2:0] gap_cnt;
  logic second_pass;
  logic halt_kind;
  logic irq_blocked;
  logic [sbc_pkg::DATA_W-1:0] wdata;
  logic [sbc_pkg::ADDR_W:1] launch_addr;
  logic [2:0] launch_stat;
  logic launch_high_n;
  logic launch_low_n;

  // Request and completion decode
  wire irq_pending = maskable_irq_in && irq_enable && !irq_blocked;
  wire wake = nmi_in || (irq_pending && !halt_kind);
  wire internal_ready = (cycle == sbc_pkg::cy_inta1)
      || (cycle == sbc_pkg::cy_inta2 && !vector_external);
  wire done = (state == sbc_pkg::st_t2)
      && (internal_ready || !bus.ready_n);
  wire plain_access = (cycle == sbc_pkg::cy_read) || (cycle == sbc_pkg::cy_write);
  wire word_access = !bus.high_byte_enable_n && !bus.low_byte_enable_n;
  // Special cycles and low-byte accesses never see the narrow input
  wire widen = done && plain_access && word_access
      && !bus.narrow_bus_size_n && !second_pass;
  wire launch = (next_state == sbc_pkg::st_t1);
  wire take_req = (state == sbc_pkg::st_idle) && launch
      && ((next_cycle == sbc_pkg::cy_read) || (next_cycle == sbc_pkg::cy_write));
  wire high_only = req_low_n && !req_high_n;
  // Byte source for lane copies: held data on an added cycle, else the request
  wire [sbc_pkg::DATA_W-1:0] write_src = widen ? wdata : req_wdata;

  assign req_ready = take_req;

  // Bus sequencing; refresh outranks hold, hold outranks new cycles
  always_comb
  begin
    next_state = state;
    next_cycle = cycle;
    unique case (state)
      sbc_pkg::st_idle:
      begin
        if (refresh_req)
        begin
          next_state = sbc_pkg::st_t1;
          next_cycle = sbc_pkg::cy_refresh;
        end
        else if (bus.hold_req)
          next_state = sbc_pkg::st_hold;
        else if (halted && !wake)
          next_state = sbc_pkg::st_idle;
        else if (irq_pending)
        begin
          next_state = sbc_pkg::st_t1;
          next_cycle = sbc_pkg::cy_inta1;
        end
        else if (nmi_in && halted)
          next_state = sbc_pkg::st_idle;
        else if (halt_req || shutdown_req)
        begin
          next_state = sbc_pkg::st_t1;
          next_cycle = halt_req ? sbc_pkg::cy_halt : sbc_pkg::cy_shut;
        end
        else if (req_valid)
        begin
          next_state = sbc_pkg::st_t1;
          next_cycle = req_write ? sbc_pkg::cy_write : sbc_pkg::cy_read;
        end
      end
      sbc_pkg::st_t1:
        next_state = sbc_pkg::st_t2;
      sbc_pkg::st_t2:
      begin
        if (widen)
          next_state = sbc_pkg::st_t1;
        else if (done && cycle == sbc_pkg::cy_inta1)
          next_state = sbc_pkg::st_gap;
        else if (done)
          next_state = sbc_pkg::st_idle;
      end
      sbc_pkg::st_gap:
      begin
        if (gap_cnt == sbc_pkg::GAP_LAST)
        begin
          next_state = sbc_pkg::st_t1;
          next_cycle = sbc_pkg::cy_inta2;
        end
      end
      sbc_pkg::st_hold:
      begin
        if (!bus.hold_req)
          next_state = sbc_pkg::st_idle;
      end
      default:
        next_state = sbc_pkg::st_idle;
    endcase
  end

  // Address, enables and status for the cycle about to start
  always_comb
  begin
    launch_addr = req_addr;
    launch_stat = req_write ? sbc_pkg::STAT_WRITE : sbc_pkg::STAT_READ;
    launch_high_n = req_high_n;
    launch_low_n = req_low_n;
    unique case (next_cycle)
      sbc_pkg::cy_read, sbc_pkg::cy_write:
      begin
        if (widen)
        begin
          launch_addr = bus.addr;
          launch_stat = {bus.mem_io, bus.data_ctrl, bus.write_read};
          launch_high_n = 1'b0;
          launch_low_n = 1'b1;
        end
      end
      sbc_pkg::cy_inta1, sbc_pkg::cy_inta2:
      begin
        // Second cycle clears A2 only, so the cascade select stays put
        launch_addr = (next_cycle == sbc_pkg::cy_inta1) ? sbc_pkg::ADDR_INTA1
            : (bus.addr & ~sbc_pkg::ADDR_INTA1);
        launch_stat = sbc_pkg::STAT_IRQ_ACK_STROBE;
        launch_high_n = 1'b1;
        launch_low_n = 1'b0;
      end
      sbc_pkg::cy_halt, sbc_pkg::cy_shut:
      begin
        launch_addr = (next_cycle == sbc_pkg::cy_halt) ? sbc_pkg::ADDR_HALT
            : sbc_pkg::ADDR_ZERO;
        launch_stat = sbc_pkg::STAT_HALT;
      end
      sbc_pkg::cy_refresh:
      begin
        launch_addr = refresh_addr;
        launch_stat = sbc_pkg::STAT_READ;
        launch_high_n = 1'b1;
        launch_low_n = 1'b1;
      end
      default:
        launch_addr = req_addr;
    endcase
  end

  // State and counters
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state <= sbc_pkg::st_idle;
      cycle <= sbc_pkg::cy_read;
      gap_cnt <= 3'h0;
      second_pass <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cycle <= next_cycle;
      gap_cnt <= (state == sbc_pkg::st_gap) ? gap_cnt + 3'h1 : 3'h0;
      second_pass <= widen || (second_pass && !done);
    end
  end

  // Address and status pins load at cycle start, cascade select one state later in the first acknowledge T1; strobe low for one state
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      bus.addr <= sbc_pkg::ADDR_ZERO;
      {bus.mem_io, bus.data_ctrl, bus.write_read} <= sbc_pkg::STAT_READ;
      bus.high_byte_enable_n <= 1'b1;
      bus.low_byte_enable_n <= 1'b1;
    end
    else if (launch)
    begin
      bus.addr <= launch_addr;
      {bus.mem_io, bus.data_ctrl, bus.write_read} <= launch_stat;
      bus.high_byte_enable_n <= launch_high_n;
      bus.low_byte_enable_n <= launch_low_n;
    end
    else if (state == sbc_pkg::st_t1 && cycle == sbc_pkg::cy_inta1 && cascade_enable)
      bus.addr[sbc_pkg::CAS_HI:sbc_pkg::CAS_LO] <= cascade_sel;
  end

  // Strobe, refresh status, lock and grant
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      bus.address_strobe_n <= 1'b1;
      bus.refresh_n <= 1'b1;
      bus.lock_n <= 1'b1;
      bus.bus_grant_ack <= 1'b0;
    end
    else
    begin
      bus.address_strobe_n <= !launch;
      bus.refresh_n <= launch ? (next_cycle != sbc_pkg::cy_refresh)
          : (bus.refresh_n || done);
      if (launch && next_cycle == sbc_pkg::cy_inta1)
        bus.lock_n <= 1'b0;
      else if (done && cycle == sbc_pkg::cy_inta2)
        bus.lock_n <= 1'b1;
      bus.bus_grant_ack <= (next_state == sbc_pkg::st_hold) && !refresh_req;
    end
  end

  // Write data drive; the bus floats for every other cycle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      bus.dev_data <= 16'h0000;
      bus.dev_data_oe <= 1'b0;
      wdata <= 16'h0000;
    end
    else if (launch && next_cycle == sbc_pkg::cy_write)
    begin
      if (!widen)
        wdata <= req_wdata;
      bus.dev_data <= (widen || high_only)
          ? {2{write_src[sbc_pkg::DATA_W-1:sbc_pkg::BYTE_W]}}
          : req_wdata;
      bus.dev_data_oe <= 1'b1;
    end
    else if (done || launch)
      bus.dev_data_oe <= 1'b0;
  end

  // Read data, vector capture and completion pulses
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      resp_valid <= 1'b0;
      resp_rdata <= 16'h0000;
      vector_valid <= 1'b0;
      irq_vector <= 8'h00;
      refresh_done <= 1'b0;
    end
    else
    begin
      resp_valid <= done && plain_access && !widen;
      if (widen)
        resp_rdata[sbc_pkg::BYTE_W-1:0] <= bus.data_bus[sbc_pkg::BYTE_W-1:0];
      else if (done && second_pass && cycle == sbc_pkg::cy_read)
        resp_rdata[sbc_pkg::DATA_W-1:sbc_pkg::BYTE_W] <=
            bus.data_bus[sbc_pkg::BYTE_W-1:0];
      else if (done && cycle == sbc_pkg::cy_read)
        resp_rdata <= bus.data_bus;
      vector_valid <= done && cycle == sbc_pkg::cy_inta2;
      if (done && cycle == sbc_pkg::cy_inta2)
        irq_vector <= vector_external ? bus.data_bus[sbc_pkg::VEC_W-1:0]
            : internal_vector;
      refresh_done <= done && cycle == sbc_pkg::cy_refresh;
    end
  end

  // Halt flag, interrupt re-arm and coprocessor service
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      halted <= 1'b0;
      halt_kind <= 1'b0;
      irq_blocked <= 1'b0;
      coproc_grant <= 1'b0;
    end
    else
    begin
      if (done && (cycle == sbc_pkg::cy_halt || cycle == sbc_pkg::cy_shut))
      begin
        halted <= 1'b1;
        halt_kind <= (cycle == sbc_pkg::cy_shut);
      end
      else if (state == sbc_pkg::st_idle && wake)
        halted <= 1'b0;
      // The request must drop before a new pair can start
      irq_blocked <= (done && cycle == sbc_pkg::cy_inta2) || (irq_blocked && maskable_irq_in);
      coproc_grant <= coproc_request;
    end
  end
endmodule : sbc_device

// file: common/sbc_pkg.sv
/*
  Shared constants and types for the special bus cycle sequencer and the
  system logic that answers it. Assumes both ends run on one 200 MHz clock.
*/
package sbc_pkg;
  // Bus widths; the address vector is indexed by address bit (A25..A1)
  localparam int ADDR_W = 25;
  localparam int DATA_W = 16;
  localparam int VEC_W = 8;
  localparam int BYTE_W = 8;
  // Cascade select field inside the address
  localparam int CAS_HI = 18;
  localparam int CAS_LO = 16;
  // Fixed addresses of special cycles
  localparam logic [ADDR_W:1] ADDR_INTA1 = 25'h0000002;
  localparam logic [ADDR_W:1] ADDR_HALT = 25'h0000001;
  localparam logic [ADDR_W:1] ADDR_ZERO = 25'h0000000;
  // Status codes {memory_or_io, data_or_control, write_or_read}
  localparam logic [2:0] STAT_IRQ_ACK_STROBE = 3'h0;
  localparam logic [2:0] STAT_HALT = 3'h5;
  localparam logic [2:0] STAT_READ = 3'h6;
  localparam logic [2:0] STAT_WRITE = 3'h7;
  // Last count of the four idle bus states between the two acknowledge cycles
  localparam logic [2:0] GAP_LAST = 3'h3;
  // Wait states the system logic inserts before ready
  localparam logic [3:0] SYS_WAITS = 4'h1;
  // Clocks beyond the first that the hold request stays released for when grant drops
  localparam logic [3:0] HOLD_RELEASE = 4'h1;

  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_t1 = 3'h1,
    st_t2 = 3'h3,
    st_gap = 3'h2,
    st_hold = 3'h4
  } sbc_state_t;

  typedef enum logic [2:0] {
    cy_read = 3'h0,
    cy_write = 3'h1,
    cy_inta1 = 3'h2,
    cy_inta2 = 3'h3,
    cy_halt = 3'h4,
    cy_shut = 3'h5,
    cy_refresh = 3'h6
  } sbc_cycle_t;
endpackage : sbc_pkg

// file: common/sbc_bus_if.sv
/*
  Local bus between the sequencer and the system logic.
  Assumes both ends share one clock; the data bus is resolved here.
*/
`timescale 1ns/1ps
interface sbc_bus_if;
  logic [sbc_pkg::ADDR_W:1] addr;
  logic high_byte_enable_n;
  logic low_byte_enable_n;
  logic address_strobe_n;
  logic mem_io;
  logic data_ctrl;
  logic write_read;
  logic refresh_n;
  logic lock_n;
  logic ready_n;
  logic narrow_bus_size_n;
  logic hold_req;
  logic bus_grant_ack;
  logic [sbc_pkg::DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic [sbc_pkg::DATA_W-1:0] sys_data;
  logic sys_data_oe;
  wire [sbc_pkg::DATA_W-1:0] data_bus;

  // Undriven data bus reads as pulled up
  assign data_bus = dev_data_oe ? dev_data : (sys_data_oe ? sys_data : 16'hFFFF);

  modport dev (
    output addr, high_byte_enable_n, low_byte_enable_n, address_strobe_n,
    output mem_io, data_ctrl, write_read, refresh_n, lock_n, bus_grant_ack,
    output dev_data, dev_data_oe,
    input ready_n, narrow_bus_size_n, hold_req, data_bus
  );
  modport sys (
    input addr, high_byte_enable_n, low_byte_enable_n, address_strobe_n,
    input mem_io, data_ctrl, write_read, refresh_n, lock_n, bus_grant_ack,
    input data_bus,
    output ready_n, narrow_bus_size_n, hold_req, sys_data, sys_data_oe
  );
endinterface : sbc_bus_if

// file: rtl/sbc_system.sv
/*
  System logic facing the sequencer: ready with wait states, narrow-bus
  sizing, cascaded vector drive, write capture and a hold-requesting master.
  Assumes the sequencer on the same clock at the other end of sbc_bus_if.
*/
`timescale 1ns/1ps
module sbc_system (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Local bus
  sbc_bus_if.sys bus,
  // Memory side
  input wire logic narrow_select,
  input wire logic [sbc_pkg::DATA_W-1:0] mem_rdata,
  output logic mem_wstrobe,
  output logic [sbc_pkg::DATA_W-1:0] mem_wdata,
  // Cascaded interrupt controller
  input wire logic ext_vector_src,
  input wire logic [sbc_pkg::VEC_W-1:0] ext_vector,
  output logic irq_ack_strobe,
  output logic halt_seen,
  // Other bus master
  input wire logic master_req,
  output logic master_granted
);
  logic busy;
  logic [3:0] wait_cnt;
  logic [3:0] release_cnt;
  logic [2:0] stat;
  logic first_ack;
  logic grant_seen;

  wire start = !bus.address_strobe_n;
  wire status_irq_ack_strobe = (stat == sbc_pkg::STAT_IRQ_ACK_STROBE);
  // First acknowledge and internal second acknowledge end on internal ready
  wire need_ready = !(status_irq_ack_strobe && (first_ack || !ext_vector_src));
  wire give_ready = busy && need_ready && (wait_cnt == sbc_pkg::SYS_WAITS);
  wire ended = busy && (give_ready || !need_ready);

  assign bus.ready_n = !give_ready;
  assign bus.narrow_bus_size_n = !(busy && narrow_select);
  assign irq_ack_strobe = busy && status_irq_ack_strobe;
  assign master_granted = bus.bus_grant_ack;

  // Cycle tracking; wait states count second bus states
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      stat <= sbc_pkg::STAT_READ;
      first_ack <= 1'b0;
      halt_seen <= 1'b0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      wait_cnt <= 4'h0;
      stat <= {bus.mem_io, bus.data_ctrl, bus.write_read};
      first_ack <= bus.addr[2];
      halt_seen <= ({bus.mem_io, bus.data_ctrl, bus.write_read} == sbc_pkg::STAT_HALT);
    end
    else
    begin
      halt_seen <= 1'b0;
      wait_cnt <= busy ? wait_cnt + 4'h1 : 4'h0;
      if (ended)
        busy <= 1'b0;
    end
  end

  // Read data and cascaded vector drive, write capture
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      bus.sys_data <= 16'h0000;
      bus.sys_data_oe <= 1'b0;
      mem_wstrobe <= 1'b0;
      mem_wdata <= 16'h0000;
    end
    else
    begin
      if (start && {bus.mem_io, bus.data_ctrl, bus.write_read} == sbc_pkg::STAT_READ
          && bus.refresh_n)
      begin
        bus.sys_data <= mem_rdata;
        bus.sys_data_oe <= 1'b1;
      end
      else if (start && {bus.mem_io, bus.data_ctrl, bus.write_read} == sbc_pkg::STAT_IRQ_ACK_STROBE
          && !bus.addr[2] && ext_vector_src)
      begin
        bus.sys_data <= {8'h00, ext_vector};
        bus.sys_data_oe <= 1'b1;
      end
      else if (ended)
        bus.sys_data_oe <= 1'b0;
      mem_wstrobe <= ended && (stat == sbc_pkg::STAT_WRITE);
      if (ended && stat == sbc_pkg::STAT_WRITE)
        mem_wdata <= bus.data_bus;
    end
  end

  // Hold request, released for a while when grant drops for refresh
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      bus.hold_req <= 1'b0;
      release_cnt <= 4'h0;
      grant_seen <= 1'b0;
    end
    else
    begin
      grant_seen <= bus.bus_grant_ack;
      if (grant_seen && !bus.bus_grant_ack && bus.hold_req)
        release_cnt <= sbc_pkg::HOLD_RELEASE;
      else if (release_cnt != 4'h0)
        release_cnt <= release_cnt - 4'h1;
      bus.hold_req <= master_req && (release_cnt == 4'h0)
          && !(grant_seen && !bus.bus_grant_ack);
    end
  end
endmodule : sbc_system

// file: dv/sbc_checker.sv
/*
  Protocol checker for the sequencer bus, built on the signals of sbc_bus_if.
  Assumes one clock and an asynchronous active-high reset for both ends.
*/
`timescale 1ns/1ps
module sbc_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Driven by the sequencer
  input wire logic [sbc_pkg::ADDR_W:1] addr,
  input wire logic high_byte_enable_n,
  input wire logic low_byte_enable_n,
  input wire logic address_strobe_n,
  input wire logic mem_io,
  input wire logic data_ctrl,
  input wire logic write_read,
  input wire logic refresh_n,
  input wire logic lock_n,
  input wire logic bus_grant_ack,
  input wire logic dev_data_oe,
  // Driven by the system logic
  input wire logic ready_n,
  input wire logic narrow_bus_size_n,
  input wire logic hold_req
);
  logic [sbc_pkg::ADDR_W:1] t1_addr;
  // Cycle decodes; status stands from T1 to the next T1
  wire ack_stat = !mem_io && !data_ctrl && !write_read;
  wire ack_st = !address_strobe_n && ack_stat;
  wire halt_st = !address_strobe_n && mem_io && !data_ctrl;
  wire ref_st = !address_strobe_n && !refresh_n;
  wire word_end = !ready_n && !narrow_bus_size_n && mem_io && data_ctrl && address_strobe_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Address of the latest T1, so an added narrow cycle can be compared with it
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      t1_addr <= '0;
    else if (!address_strobe_n)
      t1_addr <= addr;
  end

  sequence s_first_ack;
    ack_st && addr[2];
  endsequence
  sequence s_gap;
    address_strobe_n [*5];
  endsequence
  sequence s_second_ack;
    ack_st && !addr[2];
  endsequence

  a_ack_refresh_high: assert property (ack_st |-> refresh_n && !lock_n)
    else $error("acknowledge status wrong");
  a_ack_enables: assert property (ack_st |-> high_byte_enable_n && !low_byte_enable_n
    && addr[15:3] == 13'h0 && !addr[1]) else $error("acknowledge enables wrong");
  a_ack_gap_idle: assert property (s_first_ack |-> ##1 s_gap ##1 s_second_ack)
    else $error("acknowledge gap wrong");
  a_lock_no_grant: assert property (!lock_n |-> !bus_grant_ack)
    else $error("grant during lock");
  a_ack_data_float: assert property (ack_stat |-> !dev_data_oe)
    else $error("data driven in acknowledge");
  a_halt_addr_status: assert property (halt_st |-> write_read
    && (addr == sbc_pkg::ADDR_HALT || addr == sbc_pkg::ADDR_ZERO))
    else $error("halt cycle wrong");
  a_refresh_form: assert property (ref_st |-> mem_io && data_ctrl && !write_read
    && high_byte_enable_n && low_byte_enable_n) else $error("refresh cycle wrong");
  a_refresh_after_release: assert property (ref_st |-> !$past(hold_req) && !bus_grant_ack)
    else $error("refresh before hold release");
  a_narrow_same_addr: assert property (word_end && !high_byte_enable_n
    && !low_byte_enable_n |-> ##[1:3] (!address_strobe_n && low_byte_enable_n
    && !high_byte_enable_n && addr == t1_addr)) else $error("narrow second cycle wrong");
  a_low_no_extra: assert property (word_end && high_byte_enable_n |=> address_strobe_n)
    else $error("narrow ignored cycle extended");
endmodule : sbc_checker

// file: dv/tb_top.sv
/*
  Self-checking bench: sequencer and system logic face each other on one bus.
  Assumes a 200 MHz clock and the hand-over timing of both ends.
*/
`timescale 1ns/1ps
module tb_top;
  logic clock, reset, req_valid, req_write, req_high_n, req_low_n, req_ready, resp_valid;
  logic maskable_irq_in, irq_enable, nmi_in, cascade_enable, vector_external, vector_valid;
  logic halt_req, shutdown_req, halted, refresh_req, refresh_done, coproc_request, coproc_grant;
  logic narrow_select, mem_wstrobe, ext_vector_src, irq_ack_strobe, halt_seen, master_req;
  logic master_granted;
  logic [2:0] cascade_sel;
  logic [7:0] internal_vector, irq_vector, ext_vector;
  logic [15:0] req_wdata, resp_rdata, mem_rdata, mem_wdata, strobes, vecs;
  logic [15:0] wstrobes, halts, acks;
  logic [sbc_pkg::ADDR_W:1] req_addr, refresh_addr;
  int error_cnt, checked, cyc;

  sbc_bus_if sbc_bus_if_inst ();
  sbc_device sbc_device_inst (.clock, .reset, .bus(sbc_bus_if_inst.dev), .req_valid,
    .req_write, .req_high_n, .req_low_n, .req_addr, .req_wdata, .req_ready, .resp_valid,
    .resp_rdata, .maskable_irq_in, .irq_enable, .nmi_in, .cascade_enable, .cascade_sel,
    .vector_external, .internal_vector, .vector_valid, .irq_vector, .halt_req,
    .shutdown_req, .halted, .refresh_req, .refresh_addr, .refresh_done, .coproc_request,
    .coproc_grant);
  sbc_system sbc_system_inst (.clock, .reset, .bus(sbc_bus_if_inst.sys), .narrow_select,
    .mem_rdata, .mem_wstrobe, .mem_wdata, .ext_vector_src, .ext_vector, .irq_ack_strobe,
    .halt_seen, .master_req, .master_granted);
  sbc_checker sbc_checker_inst (.clock, .reset, .addr(sbc_bus_if_inst.addr),
    .high_byte_enable_n(sbc_bus_if_inst.high_byte_enable_n),
    .low_byte_enable_n(sbc_bus_if_inst.low_byte_enable_n),
    .address_strobe_n(sbc_bus_if_inst.address_strobe_n), .mem_io(sbc_bus_if_inst.mem_io),
    .data_ctrl(sbc_bus_if_inst.data_ctrl), .write_read(sbc_bus_if_inst.write_read),
    .refresh_n(sbc_bus_if_inst.refresh_n), .lock_n(sbc_bus_if_inst.lock_n),
    .bus_grant_ack(sbc_bus_if_inst.bus_grant_ack), .dev_data_oe(sbc_bus_if_inst.dev_data_oe),
    .ready_n(sbc_bus_if_inst.ready_n), .narrow_bus_size_n(sbc_bus_if_inst.narrow_bus_size_n),
    .hold_req(sbc_bus_if_inst.hold_req));

  // Clock at 200 MHz
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Counts bus cycles and vectors; a hang ends the run as a mismatch
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (!sbc_bus_if_inst.address_strobe_n) strobes <= strobes + 16'h1;
    if (vector_valid) vecs <= vecs + 16'h1;
    if (mem_wstrobe) wstrobes <= wstrobes + 16'h1;
    if (halt_seen) halts <= halts + 16'h1;
    if (irq_ack_strobe) acks <= acks + 16'h1;
    if (cyc == 3000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One access; n is the number of bus cycles it should cost
  task automatic t_access(input logic w, hn, ln, nar, input logic [15:0] wd, input int n,
                          input logic [15:0] exp);
    logic [15:0] s0, w0;
    s0 = strobes;
    w0 = wstrobes;
    narrow_select <= nar;
    req_write <= w;
    req_high_n <= hn;
    req_low_n <= ln;
    req_wdata <= wd;
    req_valid <= 1'b1;
    do @(posedge clock); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (int i = 0; i < 30 && resp_valid !== 1'b1; i++) @(posedge clock);
    chk("access data", exp, w ? mem_wdata : resp_rdata);
    chk("bus cycles", s0 + 16'(n), strobes);
    narrow_select <= 1'b0;
    // One spare edge so the last write strobe is counted before it is compared
    @(posedge clock);
    chk("write strobes", w0 + (w ? 16'(n) : 16'h0), wstrobes);
  endtask : t_access

  // Acknowledge pair, masked first, with a hold request racing it
  task automatic t_irq(input logic ext);
    logic [15:0] v0, a0;
    v0 = vecs;
    a0 = acks;
    vector_external <= ext;
    ext_vector_src <= ext;
    maskable_irq_in <= 1'b1;
    repeat (20) @(posedge clock);
    chk("masked vectors", v0, vecs);
    irq_enable <= 1'b1;
    @(posedge clock);
    master_req <= 1'b1;
    for (int i = 0; i < 60 && vecs == v0; i++) @(posedge clock);
    chk("vector", ext ? 16'h0092 : 16'h0041, {8'h0, irq_vector});
    chk("cascade", 16'h0005, {13'h0, sbc_bus_if_inst.addr[18:16]});
    chk("ack strobe", 16'h2 + (ext ? 16'(sbc_pkg::SYS_WAITS) : 16'h0), acks - a0);
    maskable_irq_in <= 1'b0;
    irq_enable <= 1'b0;
    master_req <= 1'b0;
    repeat (10) @(posedge clock);
  endtask : t_irq

  // Halt or shutdown, then the events that may end it
  task automatic t_halt(input logic shut);
    logic [15:0] h0;
    h0 = halts;
    halt_req <= !shut;
    shutdown_req <= shut;
    for (int i = 0; i < 40 && halted !== 1'b1; i++) @(posedge clock);
    halt_req <= 1'b0;
    shutdown_req <= 1'b0;
    chk("halt address", shut ? 16'h0 : 16'h2, {sbc_bus_if_inst.addr[15:1], 1'h0});
    chk("halt seen", h0 + 16'h1, halts);
    irq_enable <= 1'b1;
    maskable_irq_in <= 1'b1;
    coproc_request <= 1'b1;
    repeat (20) @(posedge clock);
    chk("halted with irq", {15'h0, shut}, {15'h0, halted});
    chk("coproc grant", 16'h1, {15'h0, coproc_grant});
    coproc_request <= 1'b0;
    nmi_in <= 1'b1;
    repeat (3) @(posedge clock);
    nmi_in <= 1'b0;
    chk("halted after nmi", 16'h0, {15'h0, halted});
    maskable_irq_in <= 1'b0;
    irq_enable <= 1'b0;
    repeat (30) @(posedge clock);
  endtask : t_halt

  // Refresh falls due while another master holds the bus
  task automatic t_refresh;
    master_req <= 1'b1;
    for (int i = 0; i < 20 && master_granted !== 1'b1; i++) @(posedge clock);
    refresh_req <= 1'b1;
    // The request is a level: drop it once the refresh cycle is on the bus
    for (int i = 0; i < 40 && sbc_bus_if_inst.refresh_n !== 1'b0; i++) @(posedge clock);
    refresh_req <= 1'b0;
    for (int i = 0; i < 40 && refresh_done !== 1'b1; i++) @(posedge clock);
    chk("refresh done", 16'h1, {15'h0, refresh_done});
    chk("refresh address", refresh_addr[16:1], sbc_bus_if_inst.addr[16:1]);
    master_req <= 1'b0;
    repeat (10) @(posedge clock);
  endtask : t_refresh

  task automatic results;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    {req_valid, req_write, req_high_n, req_low_n, maskable_irq_in, irq_enable} = 6'h0;
    {nmi_in, vector_external, halt_req, shutdown_req, refresh_req} = 5'h0;
    {coproc_request, narrow_select, ext_vector_src, master_req} = 4'h0;
    {strobes, vecs, wstrobes, halts, acks, req_wdata, error_cnt, checked, cyc} = '0;
    cascade_enable = 1'b1;
    cascade_sel = 3'h5;
    internal_vector = 8'h41;
    ext_vector = 8'h92;
    mem_rdata = 16'hA5C3;
    req_addr = 25'h0001234;
    refresh_addr = 25'h0ABCDE;
    reset = 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_access(1'b1, 1'b0, 1'b0, 1'b0, 16'h1234, 1, 16'h1234);
    t_access(1'b1, 1'b0, 1'b1, 1'b0, 16'hBE11, 1, 16'hBEBE);
    t_access(1'b1, 1'b0, 1'b0, 1'b1, 16'h7E21, 2, 16'h7E7E);
    t_access(1'b0, 1'b0, 1'b0, 1'b0, 16'h0, 1, 16'hA5C3);
    t_access(1'b0, 1'b0, 1'b0, 1'b1, 16'h0, 2, 16'hC3C3);
    t_access(1'b1, 1'b1, 1'b0, 1'b1, 16'h5555, 1, 16'h5555);
    t_irq(1'b0);
    t_irq(1'b1);
    t_halt(1'b0);
    t_halt(1'b1);
    t_refresh();
    results();
  end
endmodule : tb_top
